// >>> rtl/bscan_chain.sv
`timescale 1ns/1ns
`include "bscan_defines.svh"

module bscan_chain (
  input wire logic mclk,
  input wire logic rst_n,
  bscan_chain_if.chain cif
);
  import bscan_pkg::*;

  bscan_chain_t s_r;
  bscan_chain_t s_nxt;

  // ----------------------------------------
  // shift and update stages
  // ----------------------------------------
  always_comb begin
    s_nxt = s_r;
    if (cif.capture) begin
      s_nxt.sh = cif.cap_data;
    end else if (cif.shift) begin
      // position 0 sits next to the serial output and leaves first
      s_nxt.sh = {cif.sdi, s_r.sh[`BSCAN_MSB:1]};
    end
    if (cif.update) begin
      s_nxt.upd = s_r.sh;
    end
  end

  // enables reset to one so no pin drives before a preload
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s_r.sh <= '0;
      s_r.upd <= '1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign cif.sdo = s_r.sh[`BSCAN_POS_RSVD];
  assign cif.upd_data = s_r.upd;

endmodule : bscan_chain

// >>> rtl/bscan_chain_if.sv
`timescale 1ns/1ns

interface bscan_chain_if;
  import bscan_pkg::*;
  logic capture;
  logic shift;
  logic update;
  logic sdi;
  logic sdo;
  bscan_vec_t cap_data;
  bscan_vec_t upd_data;

  modport ctl (output capture, output shift, output update, output sdi, output cap_data,
    input sdo, input upd_data);
  modport chain (input capture, input shift, input update, input sdi, input cap_data,
    output sdo, output upd_data);
endinterface : bscan_chain_if

// >>> rtl/bscan_defines.svh
`ifndef BSCAN_DEFINES_SVH
`define BSCAN_DEFINES_SVH

// ----------------------------------------
// chain geometry
// ----------------------------------------
`define BSCAN_LEN 169
`define BSCAN_MSB 168
`define BSCAN_IR_W 4

// ----------------------------------------
// instruction codes
// ----------------------------------------
`define BSCAN_IR_BYPASS 4'hf
`define BSCAN_IR_SAMPLE 4'h2
`define BSCAN_IR_EXTEST 4'h0
`define BSCAN_IR_HIGHZ 4'h9
`define BSCAN_IR_CLAMP 4'hc
`define BSCAN_IR_CAPTURE 4'h1

// ----------------------------------------
// cell positions
// ----------------------------------------
`define BSCAN_POS_RSVD 0
`define BSCAN_DATA0_LO 1
`define BSCAN_DATA0_HI 36
`define BSCAN_DATA1_LO 78
`define BSCAN_DATA1_HI 113
`define BSCAN_ADDR_LO 114
`define BSCAN_ADDR_HI 156
`define BSCAN_ADDR_IN_LO 150
`define BSCAN_ADDR_IN_HI 152
`define BSCAN_CTL_LO 61
`define BSCAN_CTL_HI 67
`define BSCAN_POS_ABB 39
`define BSCAN_POS_FDN 46
`define BSCAN_POS_BR 48
`define BSCAN_POS_TA 49
`define BSCAN_POS_CLAIM 50
`define BSCAN_POS_AACK 52
`define BSCAN_POS_CI 53
`define BSCAN_POS_ARTRY 54
`define BSCAN_POS_WT 55
`define BSCAN_POS_DBB 59
`define BSCAN_POS_APE 157

// ----------------------------------------
// enable cell positions
// ----------------------------------------
`define BSCAN_EN_FIRST 158
`define BSCAN_EN_TA 158
`define BSCAN_EN_CLAIM 159
`define BSCAN_EN_BR 160
`define BSCAN_EN_FDN 161
`define BSCAN_EN_DBB 162
`define BSCAN_EN_DATA 163
`define BSCAN_EN_ARTRY 164
`define BSCAN_EN_APE 165
`define BSCAN_EN_ABB 166
`define BSCAN_EN_AACK 167
`define BSCAN_EN_ADDR 168

// ----------------------------------------
// reset and fixed capture values
// ----------------------------------------
`define BSCAN_PIN_IDLE 1'b1
`define BSCAN_RSVD_VAL 1'b1

`endif

// >>> rtl/bscan_pkg.sv
`include "bscan_defines.svh"

package bscan_pkg;

  typedef logic [`BSCAN_MSB:0] bscan_vec_t;
  typedef logic [`BSCAN_IR_W-1:0] bscan_ir_t;

  typedef enum logic [3:0] {
    BSCAN_TLR = 4'h0,
    BSCAN_RTI = 4'h1,
    BSCAN_SEL_DR = 4'h3,
    BSCAN_CAP_DR = 4'h2,
    BSCAN_SH_DR = 4'h6,
    BSCAN_EX1_DR = 4'h7,
    BSCAN_PAU_DR = 4'h5,
    BSCAN_EX2_DR = 4'h4,
    BSCAN_UPD_DR = 4'hc,
    BSCAN_SEL_IR = 4'hd,
    BSCAN_CAP_IR = 4'hf,
    BSCAN_SH_IR = 4'he,
    BSCAN_EX1_IR = 4'ha,
    BSCAN_PAU_IR = 4'hb,
    BSCAN_EX2_IR = 4'h9,
    BSCAN_UPD_IR = 4'h8
  } bscan_state_t;

  typedef struct packed {
    logic [2:0] tck_s;
    logic [1:0] tms_s;
    logic [1:0] tdi_s;
    logic [1:0] trst_s;
    bscan_vec_t pad_s1;
    bscan_vec_t pad_s2;
    bscan_state_t st;
    bscan_ir_t ir_sh;
    bscan_ir_t ir;
    logic byp;
    logic tdo;
    logic tdo_oe;
    bscan_vec_t pad_o;
    bscan_vec_t pad_oe;
  } bscan_top_t;

  typedef struct packed {
    bscan_vec_t sh;
    bscan_vec_t upd;
  } bscan_chain_t;

endpackage : bscan_pkg

// >>> rtl/bscan_top.sv
`timescale 1ns/1ns
`include "bscan_defines.svh"

// Summary of operation
// - undriven data and mode inputs read one
// - state moves on sampled mode, clock rise
// - position zero shifts out first
// - enable one releases pins, zero drives
// - enable cells are pinless chain stages
// - each driven cell follows its enable
// - bidirectional cells capture and drive
// - positions 1..36 data, one shared enable
// - chain holds 169 cells
// - instruction decode, bypass after reset
// - serial output drives only while shifting
module bscan_top (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  input wire logic trst_n,
  output logic tdo,
  output logic tdo_oe,
  input wire bscan_pkg::bscan_vec_t pad_i,
  output bscan_pkg::bscan_vec_t pad_o,
  output bscan_pkg::bscan_vec_t pad_oe,
  input wire bscan_pkg::bscan_vec_t core_o,
  input wire bscan_pkg::bscan_vec_t core_oe,
  output bscan_pkg::bscan_vec_t core_i
);
  import bscan_pkg::*;

  // ----------------------------------------
  // reset release
  // ----------------------------------------
  logic [1:0] rst_sync_r;
  logic rst_n;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_r[1];

  // ----------------------------------------
  // cell map
  // ----------------------------------------
  function automatic logic [7:0] en_of(input int i);
    logic [7:0] e;
    e = 8'h00;
    if ((i >= `BSCAN_DATA0_LO && i <= `BSCAN_DATA0_HI) ||
        (i >= `BSCAN_DATA1_LO && i <= `BSCAN_DATA1_HI)) begin
      e = 8'(`BSCAN_EN_DATA);
    end else if (i >= `BSCAN_ADDR_LO && i <= `BSCAN_ADDR_HI &&
        !(i >= `BSCAN_ADDR_IN_LO && i <= `BSCAN_ADDR_IN_HI)) begin
      e = 8'(`BSCAN_EN_ADDR);
    end else if ((i >= `BSCAN_CTL_LO && i <= `BSCAN_CTL_HI) ||
        i == `BSCAN_POS_CI || i == `BSCAN_POS_WT) begin
      e = 8'(`BSCAN_EN_ADDR);
    end else begin
      case (i)
        `BSCAN_POS_ABB: e = 8'(`BSCAN_EN_ABB);
        `BSCAN_POS_FDN: e = 8'(`BSCAN_EN_FDN);
        `BSCAN_POS_BR: e = 8'(`BSCAN_EN_BR);
        `BSCAN_POS_TA: e = 8'(`BSCAN_EN_TA);
        `BSCAN_POS_CLAIM: e = 8'(`BSCAN_EN_CLAIM);
        `BSCAN_POS_AACK: e = 8'(`BSCAN_EN_AACK);
        `BSCAN_POS_ARTRY: e = 8'(`BSCAN_EN_ARTRY);
        `BSCAN_POS_DBB: e = 8'(`BSCAN_EN_DBB);
        `BSCAN_POS_APE: e = 8'(`BSCAN_EN_APE);
        default: e = 8'h00;
      endcase
    end
    return e;
  endfunction : en_of

  // ----------------------------------------
  // state and chain link
  // ----------------------------------------
  bscan_top_t s_r;
  bscan_top_t s_nxt;
  bscan_chain_if cif ();

  logic tck_rise;
  logic tck_fall;
  logic tms_v;
  logic tdi_v;
  logic bsr_sel;
  logic ext_mode;
  logic hiz_mode;

  assign tck_rise = s_r.tck_s[1] & ~s_r.tck_s[2];
  assign tck_fall = ~s_r.tck_s[1] & s_r.tck_s[2];
  assign tms_v = s_r.tms_s[1];
  assign tdi_v = s_r.tdi_s[1];
  assign bsr_sel = (s_r.ir == `BSCAN_IR_EXTEST) || (s_r.ir == `BSCAN_IR_SAMPLE);
  assign ext_mode = (s_r.ir == `BSCAN_IR_EXTEST) || (s_r.ir == `BSCAN_IR_CLAMP);
  assign hiz_mode = (s_r.ir == `BSCAN_IR_HIGHZ);

  bscan_chain u_chain (
    .mclk(mclk),
    .rst_n(rst_n),
    .cif(cif)
  );

  // ----------------------------------------
  // capture vector and chain strobes
  // ----------------------------------------
  always_comb begin
    bscan_vec_t cv;
    cv = s_r.pad_s2;
    cv[`BSCAN_POS_RSVD] = `BSCAN_RSVD_VAL;
    // enable cells have no pad, so they capture their own held state
    for (int i = `BSCAN_EN_FIRST; i < `BSCAN_LEN; i++) begin
      cv[i] = cif.upd_data[i];
    end
    cif.cap_data = cv;
    cif.capture = tck_rise && bsr_sel && (s_r.st == BSCAN_CAP_DR);
    cif.shift = tck_rise && bsr_sel && (s_r.st == BSCAN_SH_DR);
    cif.update = tck_fall && bsr_sel && (s_r.st == BSCAN_UPD_DR);
    cif.sdi = tdi_v;
  end

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    logic [7:0] e;
    s_nxt = s_r;
    e = 8'h00;
    s_nxt.tck_s = {s_r.tck_s[1:0], tck};
    s_nxt.tms_s = {s_r.tms_s[0], tms};
    s_nxt.tdi_s = {s_r.tdi_s[0], tdi};
    s_nxt.trst_s = {s_r.trst_s[0], trst_n};
    s_nxt.pad_s1 = pad_i;
    s_nxt.pad_s2 = s_r.pad_s1;

    if (tck_rise) begin
      unique case (s_r.st)
        BSCAN_TLR: s_nxt.st = tms_v ? BSCAN_TLR : BSCAN_RTI;
        BSCAN_RTI: s_nxt.st = tms_v ? BSCAN_SEL_DR : BSCAN_RTI;
        BSCAN_SEL_DR: s_nxt.st = tms_v ? BSCAN_SEL_IR : BSCAN_CAP_DR;
        BSCAN_CAP_DR: s_nxt.st = tms_v ? BSCAN_EX1_DR : BSCAN_SH_DR;
        BSCAN_SH_DR: s_nxt.st = tms_v ? BSCAN_EX1_DR : BSCAN_SH_DR;
        BSCAN_EX1_DR: s_nxt.st = tms_v ? BSCAN_UPD_DR : BSCAN_PAU_DR;
        BSCAN_PAU_DR: s_nxt.st = tms_v ? BSCAN_EX2_DR : BSCAN_PAU_DR;
        BSCAN_EX2_DR: s_nxt.st = tms_v ? BSCAN_UPD_DR : BSCAN_SH_DR;
        BSCAN_UPD_DR: s_nxt.st = tms_v ? BSCAN_SEL_DR : BSCAN_RTI;
        BSCAN_SEL_IR: s_nxt.st = tms_v ? BSCAN_TLR : BSCAN_CAP_IR;
        BSCAN_CAP_IR: s_nxt.st = tms_v ? BSCAN_EX1_IR : BSCAN_SH_IR;
        BSCAN_SH_IR: s_nxt.st = tms_v ? BSCAN_EX1_IR : BSCAN_SH_IR;
        BSCAN_EX1_IR: s_nxt.st = tms_v ? BSCAN_UPD_IR : BSCAN_PAU_IR;
        BSCAN_PAU_IR: s_nxt.st = tms_v ? BSCAN_EX2_IR : BSCAN_PAU_IR;
        BSCAN_EX2_IR: s_nxt.st = tms_v ? BSCAN_UPD_IR : BSCAN_SH_IR;
        BSCAN_UPD_IR: s_nxt.st = tms_v ? BSCAN_SEL_DR : BSCAN_RTI;
      endcase
      if (s_r.st == BSCAN_CAP_IR) begin
        s_nxt.ir_sh = `BSCAN_IR_CAPTURE;
      end else if (s_r.st == BSCAN_SH_IR) begin
        s_nxt.ir_sh = {tdi_v, s_r.ir_sh[`BSCAN_IR_W-1:1]};
      end
      if (!bsr_sel && s_r.st == BSCAN_CAP_DR) begin
        s_nxt.byp = 1'b0;
      end else if (!bsr_sel && s_r.st == BSCAN_SH_DR) begin
        s_nxt.byp = tdi_v;
      end
    end

    if (tck_fall) begin
      if (s_r.st == BSCAN_UPD_IR) begin
        s_nxt.ir = s_r.ir_sh;
      end
      // serial output changes on the falling edge, away from the sampling edge
      s_nxt.tdo_oe = (s_r.st == BSCAN_SH_IR) || (s_r.st == BSCAN_SH_DR);
      if (s_r.st == BSCAN_SH_IR) begin
        s_nxt.tdo = s_r.ir_sh[0];
      end else if (s_r.st == BSCAN_SH_DR) begin
        s_nxt.tdo = bsr_sel ? cif.sdo : s_r.byp;
      end
    end

    // test reset pin overrides the clock-driven path
    if (!s_r.trst_s[1]) begin
      s_nxt.st = BSCAN_TLR;
      s_nxt.tdo_oe = 1'b0;
    end
    if (s_r.st == BSCAN_TLR) begin
      s_nxt.ir = `BSCAN_IR_BYPASS;
    end

    // pad drive: functional path unless a test mode owns the pins
    for (int i = 0; i < `BSCAN_LEN; i++) begin
      e = en_of(i);
      if (e == 8'h00) begin
        s_nxt.pad_o[i] = 1'b0;
        s_nxt.pad_oe[i] = 1'b0;
      end else if (hiz_mode) begin
        s_nxt.pad_o[i] = 1'b0;
        s_nxt.pad_oe[i] = 1'b0;
      end else if (ext_mode) begin
        s_nxt.pad_o[i] = cif.upd_data[i];
        s_nxt.pad_oe[i] = ~cif.upd_data[e];
      end else begin
        s_nxt.pad_o[i] = core_o[i];
        s_nxt.pad_oe[i] = core_oe[i];
      end
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  // idle levels of one stand in for the pull-ups on open inputs
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s_r.tck_s <= 3'h0;
      s_r.tms_s <= {2{`BSCAN_PIN_IDLE}};
      s_r.tdi_s <= {2{`BSCAN_PIN_IDLE}};
      s_r.trst_s <= 2'h0;
      s_r.pad_s1 <= '0;
      s_r.pad_s2 <= '0;
      s_r.st <= BSCAN_TLR;
      s_r.ir_sh <= `BSCAN_IR_CAPTURE;
      s_r.ir <= `BSCAN_IR_BYPASS;
      s_r.byp <= 1'b0;
      s_r.tdo <= 1'b0;
      s_r.tdo_oe <= 1'b0;
      s_r.pad_o <= '0;
      s_r.pad_oe <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign tdo = s_r.tdo;
  assign tdo_oe = s_r.tdo_oe;
  assign pad_o = s_r.pad_o;
  assign pad_oe = s_r.pad_oe;
  assign core_i = s_r.pad_s2;

endmodule : bscan_top

// >>> tb/bscan_tester.sv
`timescale 1ns/1ns

module bscan_tester (
  input wire logic mclk,
  output logic tck,
  output logic tms,
  output logic tdi,
  input wire logic tdo
);
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
  end

  // tck stands low between steps; open lines float high
  task automatic step(input logic m, input logic d, output logic q);
    @(posedge mclk);
    tms <= m;
    tdi <= d;
    repeat (4) @(posedge mclk);
    q = tdo;
    tck <= 1'b1;
    repeat (4) @(posedge mclk);
    tck <= 1'b0;
    tms <= 1'b1;
    tdi <= 1'b1;
  endtask : step
endmodule : bscan_tester

// >>> tb/bscan_top_asserts.sv
`timescale 1ns/1ns

module bscan_top_asserts (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  input wire logic trst_n,
  input wire logic tdo,
  input wire logic tdo_oe,
  input wire bscan_pkg::bscan_vec_t pad_i,
  input wire bscan_pkg::bscan_vec_t pad_o,
  input wire bscan_pkg::bscan_vec_t pad_oe,
  input wire bscan_pkg::bscan_vec_t core_o,
  input wire bscan_pkg::bscan_vec_t core_oe,
  input wire bscan_pkg::bscan_vec_t core_i
);
  import bscan_pkg::*;
  // settle count: reset sync and pad sync must drain first
  logic [2:0] up_r;
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) up_r <= 3'h0;
    else if (up_r != 3'h7) up_r <= up_r + 3'h1;
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);

  core_sync_a: assert property (up_r == 3'h7 |-> core_i == $past(pad_i, 2))
    else $error("core input copy wrong");
  oe_pins_a: assert property (up_r == 3'h7 |-> pad_oe[0] == 1'b0 && pad_oe[168:158] == '0
    && pad_oe[152:150] == '0 && pad_oe[38:37] == '0) else $error("undrivable pin driven");
  tdo_hold_a: assert property (up_r == 3'h7 && $changed(tdo) |-> !$past(tck, 2))
    else $error("serial out moved off a fall");
  oe_hold_a: assert property (up_r == 3'h7 && $changed(tdo_oe) |-> !$past(tck, 2))
    else $error("serial enable moved off a fall");
  trst_quiet_a: assert property (!trst_n [*5] |-> !tdo_oe)
    else $error("serial out drives in test reset");
  trst_core_a: assert property (!trst_n [*8] |-> pad_oe[36:1] == $past(core_oe[36:1])
    && pad_o[36:1] == $past(core_o[36:1])) else $error("core path not restored");
  data_en_a: assert property (up_r == 3'h7 && pad_oe[36:1] != $past(core_oe[36:1])
    |-> pad_oe[36:1] == '0 || pad_oe[36:1] == '1) else $error("low data enables split");
  hdata_en_a: assert property (up_r == 3'h7 && pad_oe[113:78] != $past(core_oe[113:78])
    |-> pad_oe[113:78] == '0 || pad_oe[113:78] == '1) else $error("high data enables split");
endmodule : bscan_top_asserts

bind bscan_top bscan_top_asserts chk_u (.mclk(mclk), .arst_n(arst_n), .tck(tck), .tms(tms),
  .tdi(tdi), .trst_n(trst_n), .tdo(tdo), .tdo_oe(tdo_oe), .pad_i(pad_i), .pad_o(pad_o),
  .pad_oe(pad_oe), .core_o(core_o), .core_oe(core_oe), .core_i(core_i));

// >>> tb/tb.sv
`timescale 1ns/1ns
`include "bscan_defines.svh"

module tb;
  import bscan_pkg::*;
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic trst_n = 1'b1;
  logic tck, tms, tdi, tdo, tdo_oe, tdo_w, q;
  bscan_vec_t pad_i, core_o, core_oe, pad_o, pad_oe, core_i, pv, dv, ex;
  int fails = 0;
  int n_tests = 0;

  initial begin
    forever #5 mclk = ~mclk;
  end
  // released serial line shows the inverse, never a lucky match
  assign tdo_w = tdo_oe ? tdo : ~tdo;

  bscan_top dut_u (.mclk(mclk), .arst_n(arst_n), .tck(tck), .tms(tms), .tdi(tdi),
    .trst_n(trst_n), .tdo(tdo), .tdo_oe(tdo_oe), .pad_i(pad_i), .pad_o(pad_o),
    .pad_oe(pad_oe), .core_o(core_o), .core_oe(core_oe), .core_i(core_i));
  bscan_tester tst_u (.mclk(mclk), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo_w));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input bscan_vec_t got, input bscan_vec_t exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic final_report;
    $display("checks=%0d mismatches=%0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : final_report

  function automatic int en_of(int i);
    if ((i >= 1 && i <= 36) || (i >= 78 && i <= 113)) return `BSCAN_EN_DATA;
    if ((i >= 114 && i <= 156 && !(i >= 150 && i <= 152)) || i == 53 || i == 55) return 168;
    if (i >= 61 && i <= 67) return `BSCAN_EN_ADDR;
    case (i)
      39: return 166;
      46: return 161;
      48: return 160;
      49: return 158;
      50: return 159;
      52: return 167;
      54: return 164;
      59: return 162;
      157: return 165;
      default: return -1;
    endcase
  endfunction : en_of

  // from run-test/idle, through one scan, back to idle
  task automatic scan(input bit ir, input int n, input bscan_vec_t din, output bscan_vec_t dout);
    dout = '0;
    tst_u.step(1'b1, 1'b1, q);
    if (ir) tst_u.step(1'b1, 1'b1, q);
    tst_u.step(1'b0, 1'b1, q);
    tst_u.step(1'b0, 1'b1, q);
    for (int i = 0; i < n; i++) begin
      tst_u.step(i == n - 1, din[i], q);
      dout[i] = q;
    end
    tst_u.step(1'b1, 1'b1, q);
    tst_u.step(1'b0, 1'b1, q);
  endtask : scan

  // mode 0 core path, 1 boundary drive, 2 all released
  task automatic pins(input int mode);
    int e;
    for (int i = 0; i < `BSCAN_LEN; i++) begin
      e = en_of(i);
      if (e < 0) chk(pad_oe[i], 1'b0);
      else if (mode == 0) chk(pad_oe[i], core_oe[i]);
      else if (mode == 2) chk(pad_oe[i], 1'b0);
      else chk(pad_oe[i], !pv[e]);
      if (e >= 0 && mode == 1) chk(pad_o[i], pv[i]);
      if (e >= 0 && mode == 0) chk(pad_o[i], core_o[i]);
    end
  endtask : pins

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_bypass;
    scan(1'b0, 2, '1, dv);
    chk(dv[1:0], 2'b10);
  endtask : t_bypass

  task automatic load(input bscan_ir_t c, input int mode);
    scan(1'b1, 4, c, dv);
    chk(dv[3:0], 4'h1);
    pins(mode);
  endtask : load

  task automatic t_sample;
    load(`BSCAN_IR_SAMPLE, 0);
    scan(1'b0, `BSCAN_LEN, pv, dv);
    for (int i = 0; i < `BSCAN_LEN; i++) ex[i] = (i == 0 || i >= `BSCAN_EN_FIRST) ? 1'b1 : pad_i[i];
    chk(dv, ex);
  endtask : t_sample

  // enable cells hold no pad, so a capture returns the preloaded state
  task automatic t_extest;
    load(`BSCAN_IR_EXTEST, 1);
    scan(1'b0, `BSCAN_LEN, pv, dv);
    for (int i = 0; i < `BSCAN_LEN; i++) begin
      ex[i] = (i == 0) ? 1'b1 : (i >= `BSCAN_EN_FIRST) ? pv[i] : pad_i[i];
    end
    chk(dv, ex);
    pins(1);
  endtask : t_extest

  task automatic t_clamp_highz;
    load(`BSCAN_IR_CLAMP, 1);
    t_bypass;
    load(`BSCAN_IR_HIGHZ, 2);
    t_bypass;
  endtask : t_clamp_highz

  task automatic t_five_high;
    load(`BSCAN_IR_EXTEST, 1);
    repeat (5) tst_u.step(1'b1, 1'b1, q);
    tst_u.step(1'b0, 1'b1, q);
    pins(0);
    t_bypass;
  endtask : t_five_high

  // test reset lands at the start of a data shift, before any bit moves, while the serial output drives
  task automatic t_trst;
    load(`BSCAN_IR_EXTEST, 1);
    tst_u.step(1'b1, 1'b1, q);
    tst_u.step(1'b0, 1'b1, q);
    tst_u.step(1'b0, 1'b1, q);
    repeat (4) @(posedge mclk);
    chk(tdo_oe, 1'b1);
    trst_n <= 1'b0;
    repeat (10) @(posedge mclk);
    chk(tdo_oe, 1'b0);
    trst_n <= 1'b1;
    repeat (4) @(posedge mclk);
    tst_u.step(1'b0, 1'b1, q);
    pins(0);
    t_bypass;
  endtask : t_trst

  initial begin
    for (int i = 0; i < `BSCAN_LEN; i++) begin
      pad_i[i] = (i % 4 == 1) || (i % 7 == 0);
      core_o[i] = (i % 3 == 0);
      core_oe[i] = (i % 2 == 0);
      pv[i] = ((i * 7) % 5) < 2;
    end
    pv[`BSCAN_POS_RSVD] = `BSCAN_RSVD_VAL;
    pv[`BSCAN_EN_DATA] = 1'b0;
    repeat (8) @(posedge mclk);
    arst_n <= 1'b1;
    repeat (6) @(posedge mclk);
    tst_u.step(1'b0, 1'b1, q);
    t_bypass;
    pins(0);
    t_sample;
    t_extest;
    t_clamp_highz;
    t_five_high;
    t_trst;
    final_report;
  end

  // a full run takes about 4000 cycles
  initial begin
    repeat (40000) @(posedge mclk);
    fails++;
    final_report;
  end
endmodule : tb
